// *** verilog/adc_trigger_format.sv ***
// module: trigger selection, conversion sequencing and result formatting with wishbone slave
// Functional notes
// - codes 0..9: none, capcomp, timers, comparators
// - codes 10..20 other sources; 21..31 reserved
// - triggers act on rising edge only
// - timer0/1 wrap still sets own flag
// - select low bits read zero; reset clears
// - left justify: high=9..2, low[7:6]=1..0
// - right justify: high[1:0]=9..8, low=7..0
// - results writable, kept across soft resets
// - unused result bits cleared on load
// - status bit starts, hardware clears on done
`timescale 1ns/1ps
module adc_trigger_format
	import adc_trig_pkg::*;
#(
	parameter int CONV_CYCLES = CONV_CYCLES_DEFAULT // clocks per conversion
) (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        por_i,            // power-on / brown-out reset
	// wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [3:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// trigger sources
	input  wire logic        capcomp1_output_i,
	input  wire logic        capcomp2_output_i,
	input  wire logic        timer0_wrap_i,
	input  wire logic        timer1_wrap_i,
	input  wire logic        timer2_post_event_i,
	input  wire logic        comparator1_synced_i,
	input  wire logic        comparator2_synced_i,
	input  wire logic        timer4_post_event_i,
	input  wire logic        timer6_post_event_i,
	input  wire logic        measure_timer1_match_i,
	input  wire logic        measure_timer2_match_i,
	input  wire logic        timer3_wrap_i,
	input  wire logic        timer5_wrap_i,
	input  wire logic        logic_cell1_output_i,
	input  wire logic        logic_cell2_output_i,
	input  wire logic        logic_cell3_output_i,
	input  wire logic        logic_cell4_output_i,
	input  wire logic        angular_compare1_i,
	input  wire logic        angular_compare2_i,
	input  wire logic        angular_compare3_i,
	// analog core
	input  wire logic [9:0]  conversion_result_i, // sampled at end of conversion
	output logic             convert_busy_o,
	output logic             timer0_flag_set_o,   // timer0 wrap seen
	output logic             timer1_flag_set_o    // timer1 wrap seen
);
	// ********************************
	// state and registers
	// ********************************
	typedef enum {ST_IDLE, ST_CONVERT} conv_state_t;
	conv_state_t  state_q, state_d;          // conversion sequencer
	logic [4:0]   trig_code_q;               // trigger_source_code
	logic         enable_q;                  // converter_enable
	logic         justify_q;                 // justify_select
	logic [7:0]   result_high_q, result_high_d;
	logic [7:0]   result_low_q, result_low_d;
	logic [15:0]  count_q, count_d;          // conversion clock count
	logic [31:0]  dat_q;
	logic         ack_q;
	logic         t0_flag_q, t1_flag_q;
	logic         busy_q;                    // registered busy level for the pin

	// ********************************
	// bus decode
	// ********************************
	wire bus_req    = cyc_i & stb_i & ~ack_q;
	wire bus_wr     = bus_req & we_i & sel_i[0];
	wire wr_control = bus_wr & (adr_i == OFF_CONTROL);
	wire wr_trig    = bus_wr & (adr_i == OFF_TRIG_SELECT);
	wire wr_high    = bus_wr & (adr_i == OFF_RESULT_HIGH);
	wire wr_low     = bus_wr & (adr_i == OFF_RESULT_LOW);

	// ********************************
	// trigger synchronise and select
	// ********************************
	wire [NUM_SOURCES-1:0] src_raw = {
		angular_compare3_i, angular_compare2_i, angular_compare1_i,
		logic_cell4_output_i, logic_cell3_output_i, logic_cell2_output_i,
		logic_cell1_output_i, timer5_wrap_i, timer3_wrap_i,
		measure_timer2_match_i, measure_timer1_match_i,
		timer6_post_event_i, timer4_post_event_i,
		comparator2_synced_i, comparator1_synced_i, timer2_post_event_i,
		timer1_wrap_i, timer0_wrap_i, capcomp2_output_i, capcomp1_output_i};
	logic [NUM_SOURCES-1:0] src_rise; // one-cycle rising edge per source

	// every source passes a synchroniser before its edge is taken
	trig_edge_sync #(.N(NUM_SOURCES)) u_sync (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.src_i  (src_raw),
		.rise_o (src_rise)
	);

	// code n selects bit n-1; none and reserved codes select nothing
	wire code_valid = (trig_code_q != TRIG_NONE) && (trig_code_q <= TRIG_LAST);
	wire [4:0] code_idx = trig_code_q - 5'h01;
	// padded to 32 so every 5-bit index stays in range
	wire [31:0] rise_all = 32'(src_rise);
	wire trig_rise  = code_valid & rise_all[code_idx];
	wire idle       = (state_q == ST_IDLE);
	wire sw_start   = wr_control & dat_i[CTL_BUSY_BIT] & (enable_q | dat_i[CTL_ENABLE_BIT]);
	wire hw_start   = trig_rise & enable_q;
	wire done       = (state_q == ST_CONVERT) && (count_q == 16'(CONV_CYCLES - 1));

	// ********************************
	// conversion sequencer
	// ********************************
	always_comb
	begin
		state_d = state_q;
		count_d = count_q;
		unique case (state_q)
			ST_IDLE:
			begin
				// software write or trigger edge starts alike
				if (sw_start | hw_start)
				begin
					state_d = ST_CONVERT;
					count_d = 16'h0000;
				end
			end
			ST_CONVERT:
			begin
				// disabling aborts; completion clears busy
				if (!enable_q || done)
					state_d = ST_IDLE;
				else
					count_d = count_q + 16'h0001;
			end
		endcase
	end

	// ********************************
	// result formatting
	// ********************************
	always_comb
	begin
		result_high_d = result_high_q;
		result_low_d  = result_low_q;
		if (rst_i)
		begin
			// a soft reset holds both results, even against a load or write
			result_high_d = result_high_q;
			result_low_d  = result_low_q;
		end
		else if (done && enable_q)
		begin
			if (justify_q)
			begin
				// right: upper six bits of high forced low
				result_high_d = {6'b00_0000, conversion_result_i[9:8]};
				result_low_d  = conversion_result_i[7:0];
			end
			else
			begin
				// left: lower six bits of low forced low
				result_high_d = conversion_result_i[9:2];
				result_low_d  = {conversion_result_i[1:0], 6'b00_0000};
			end
		end
		else
		begin
			if (wr_high)
				result_high_d = dat_i[7:0];
			if (wr_low)
				result_low_d = dat_i[7:0];
		end
	end

	// ********************************
	// read mux
	// ********************************
	wire [7:0] ctl_rd  = {justify_q, 5'b0_0000, ~idle, enable_q};
	wire [7:0] trig_rd = {trig_code_q, 3'b000};
	wire [7:0] rd_byte = (adr_i == OFF_CONTROL)     ? ctl_rd :
	                     (adr_i == OFF_TRIG_SELECT) ? trig_rd :
	                     (adr_i == OFF_RESULT_HIGH) ? result_high_q :
	                     (adr_i == OFF_RESULT_LOW)  ? result_low_q : 8'h00;

	// ********************************
	// control registers, cleared by the soft reset rst_i only
	// ********************************
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_q     <= ST_IDLE;
			busy_q      <= 1'b0;
			count_q     <= 16'h0000;
			trig_code_q <= TRIG_SELECT_RESET[TRIG_MSB:TRIG_LSB];
			enable_q    <= CONTROL_RESET[CTL_ENABLE_BIT];
			justify_q   <= CONTROL_RESET[CTL_JUSTIFY_BIT];
			ack_q       <= 1'b0;
			dat_q       <= 32'h0000_0000;
			t0_flag_q   <= 1'b0;
			t1_flag_q   <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			busy_q  <= (state_d == ST_CONVERT);
			count_q <= count_d;
			ack_q   <= bus_req;
			dat_q   <= bus_req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
			if (wr_trig)
				trig_code_q <= dat_i[TRIG_MSB:TRIG_LSB];
			if (wr_control)
			begin
				enable_q  <= dat_i[CTL_ENABLE_BIT];
				justify_q <= dat_i[CTL_JUSTIFY_BIT];
			end
			// timer wraps keep reaching their own flags, selected or not
			t0_flag_q <= src_rise[TRIG_TIMER0 - 5'h01];
			t1_flag_q <= src_rise[TRIG_TIMER1 - 5'h01];
		end
	end

	// ********************************
	// result registers: only power-on clears
	// ********************************
	always_ff @(posedge clk_i)
	begin
		if (por_i)
		begin
			result_high_q <= 8'h00;
			result_low_q  <= 8'h00;
		end
		else
		begin
			result_high_q <= result_high_d;
			result_low_q  <= result_low_d;
		end
	end

	// ********************************
	// outputs
	// ********************************
	assign dat_o             = dat_q;
	assign ack_o             = ack_q;
	assign convert_busy_o    = busy_q;
	assign timer0_flag_set_o = t0_flag_q;
	assign timer1_flag_set_o = t1_flag_q;

	// ********************************
	// checks
	// ********************************
	// a selected edge while idle and enabled starts at the next edge
	chk_edge_starts: assert property (@(posedge clk_i) disable iff (rst_i)
		idle && hw_start |=> state_q == ST_CONVERT)
		else $error("trigger edge did not start conversion");
	// with the converter off only a control write may start it
	chk_no_start_dis: assert property (@(posedge clk_i) disable iff (rst_i)
		idle && !enable_q && !wr_control |=> idle)
		else $error("conversion started while disabled");
	// whole register pair checked, not only the cleared bits
	chk_right_format: assert property (@(posedge clk_i) disable iff (rst_i || por_i)
		done && enable_q && justify_q |=> result_high_q == {6'h00, $past(conversion_result_i[9:8])}
		&& result_low_q == $past(conversion_result_i[7:0]))
		else $error("right justified load wrong");
	chk_left_format: assert property (@(posedge clk_i) disable iff (rst_i || por_i)
		done && enable_q && !justify_q |=> result_low_q == {$past(conversion_result_i[1:0]), 6'h00}
		&& result_high_q == $past(conversion_result_i[9:2]))
		else $error("left justified load wrong");
	chk_busy_clears: assert property (@(posedge clk_i) disable iff (rst_i)
		done |=> !convert_busy_o)
		else $error("busy not cleared on completion");
	chk_trig_read: assert property (@(posedge clk_i) disable iff (rst_i)
		bus_req && adr_i == OFF_TRIG_SELECT |=> dat_o[2:0] == 3'b000)
		else $error("trigger select low bits not zero");
	// no code and reserved codes must leave the sequencer idle
	chk_reserved_idle: assert property (@(posedge clk_i) disable iff (rst_i)
		idle && !wr_control && (trig_code_q == TRIG_NONE || trig_code_q > TRIG_LAST)
		|=> idle)
		else $error("reserved code produced a trigger");
	// timer wraps reach their own flags whatever is selected
	chk_timer0_flag: assert property (@(posedge clk_i) disable iff (rst_i)
		src_rise[TRIG_TIMER0 - 5'h01] |=> timer0_flag_set_o)
		else $error("timer0 flag missed");
	chk_timer1_flag: assert property (@(posedge clk_i) disable iff (rst_i)
		src_rise[TRIG_TIMER1 - 5'h01] |=> timer1_flag_set_o)
		else $error("timer1 flag missed");
	chk_result_kept: assert property (@(posedge clk_i) disable iff (por_i)
		rst_i |=> $stable(result_high_q) && $stable(result_low_q))
		else $error("result lost on soft reset");
	// the answer stands one cycle, never two
	chk_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o |=> !ack_o)
		else $error("acknowledge held for more than one cycle");
	cov_hw_start: cover property (@(posedge clk_i) idle && hw_start);
	cov_sw_start: cover property (@(posedge clk_i) idle && sw_start);
	cov_right_done: cover property (@(posedge clk_i) done && justify_q);
	cov_left_done: cover property (@(posedge clk_i) done && !justify_q);
endmodule // adc_trigger_format

// *** verilog/adc_trig_pkg.sv ***
// package: register map, field layout, trigger codes and timing for the trigger/format slice
package adc_trig_pkg;
	// ********************************
	// register word offsets (byte addresses)
	// ********************************
	localparam logic [3:0] OFF_CONTROL      = 4'h0; // enable, start/busy, justify
	localparam logic [3:0] OFF_TRIG_SELECT  = 4'h4; // auto_trigger_select
	localparam logic [3:0] OFF_RESULT_HIGH  = 4'h8; // result_high
	localparam logic [3:0] OFF_RESULT_LOW   = 4'hC; // result_low

	// ********************************
	// control register fields
	// ********************************
	localparam int CTL_ENABLE_BIT  = 0;  // converter_enable
	localparam int CTL_BUSY_BIT    = 1;  // conversion status
	localparam int CTL_JUSTIFY_BIT = 7;  // justify_select, 1 = right
	localparam int TRIG_LSB        = 3;  // trigger_source_code low bit
	localparam int TRIG_MSB        = 7;  // trigger_source_code high bit

	// ********************************
	// reset values
	// ********************************
	localparam logic [7:0] TRIG_SELECT_RESET = 8'h00;
	localparam logic [7:0] CONTROL_RESET     = 8'h00;

	// ********************************
	// trigger codes
	// ********************************
	localparam logic [4:0] TRIG_NONE      = 5'h00;
	localparam logic [4:0] TRIG_TIMER0    = 5'h03;
	localparam logic [4:0] TRIG_TIMER1    = 5'h04;
	localparam logic [4:0] TRIG_LAST      = 5'h14; // angular compare 3
	localparam int         NUM_SOURCES    = 20;    // codes 1..20

	// ********************************
	// timing
	// ********************************
	localparam int CONV_CYCLES_DEFAULT = 12; // conversion length in clocks
endpackage

// *** verilog/trig_edge_sync.sv ***
// module: per-source two-flop synchroniser plus rising edge detector
`timescale 1ns/1ps
module trig_edge_sync #(
	parameter int N = 20 // number of trigger sources
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// raw sources and their rising edges
	input  wire logic [N-1:0] src_i,
	output logic      [N-1:0] rise_o
);
	// ********************************
	// one synchroniser per source
	// ********************************
	// flops live inside each loop pass, so no vector has several writers
	genvar g;
	generate
		for (g = 0; g < N; g++)
		begin : g_src
			logic meta_q; // first stage, read only by second
			logic sync_q; // second stage
			logic last_q; // delayed copy for edge detect
			// shift chain
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
				begin
					meta_q <= 1'b0;
					sync_q <= 1'b0;
					last_q <= 1'b0;
				end
				else
				begin
					meta_q <= src_i[g];
					sync_q <= meta_q;
					last_q <= sync_q;
				end
			end
			// single cycle pulse on low-to-high only
			assign rise_o[g] = sync_q & ~last_q;
		end
	endgenerate
endmodule // trig_edge_sync

// *** test/trig_source_model.sv ***
// trigger source model: twenty level event lines from on-chip peripherals
`timescale 1ns/1ps
module trig_source_model (
	// clock
	input  wire logic        clk_i,
	// event lines, active high, in trigger code order
	output logic      [19:0] src_o
);
	// every line idles low until a test raises it
	initial src_o = 20'h0_0000;
	// one line moves just after an edge and then holds its level
	task automatic set_line(input int idx, input logic lvl);
		@(posedge clk_i);
		src_o[idx] <= lvl;
	endtask
	// all lines at once, used where nothing should be selected
	task automatic set_all(input logic lvl);
		@(posedge clk_i);
		src_o <= {20{lvl}};
	endtask
endmodule // trig_source_model

// *** test/adc_trigger_format_test.sv ***
// testbench: bus access, software and triggered starts, result formats
`timescale 1ns/1ps
module adc_trigger_format_test;
	import adc_trig_pkg::*;
	// ********************************
	// signals
	// ********************************
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        por_i = 1'b1;
	logic        cyc_i = 1'b0;
	logic        stb_i = 1'b0;
	logic        we_i  = 1'b0;
	logic [3:0]  adr_i = 4'h0;
	logic [3:0]  sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0000_0000;
	logic [9:0]  res_i = 10'h000;
	logic [31:0] dat_o;
	logic        ack_o;
	logic        busy_o;
	logic        f0_o;
	logic        f1_o;
	wire  [19:0] src;
	int          err_count = 0;
	int          tests_run = 0;
	int          f0 = 0;
	int          f1 = 0;
	int          b0;
	int          b1;
	logic [7:0]  r;
	logic [7:0]  q;
	logic [4:0]  nosel [3] = '{5'h00, 5'h15, 5'h1F};
	// 25 MHz clock
	always #20 clk_i = ~clk_i;
	// count timer flag pulses, sampled before the edge updates
	always @(posedge clk_i)
	begin
		if (f0_o === 1'b1)
			f0++;
		if (f1_o === 1'b1)
			f1++;
	end
	// ********************************
	// design and source model
	// ********************************
	trig_source_model u_src (.clk_i(clk_i), .src_o(src));
	adc_trigger_format #(.CONV_CYCLES(6)) u_dut (
		.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i),
		.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.capcomp1_output_i(src[0]), .capcomp2_output_i(src[1]),
		.timer0_wrap_i(src[2]), .timer1_wrap_i(src[3]),
		.timer2_post_event_i(src[4]), .comparator1_synced_i(src[5]),
		.comparator2_synced_i(src[6]), .timer4_post_event_i(src[7]),
		.timer6_post_event_i(src[8]), .measure_timer1_match_i(src[9]),
		.measure_timer2_match_i(src[10]), .timer3_wrap_i(src[11]),
		.timer5_wrap_i(src[12]), .logic_cell1_output_i(src[13]),
		.logic_cell2_output_i(src[14]), .logic_cell3_output_i(src[15]),
		.logic_cell4_output_i(src[16]), .angular_compare1_i(src[17]),
		.angular_compare2_i(src[18]), .angular_compare3_i(src[19]),
		.conversion_result_i(res_i), .convert_busy_o(busy_o),
		.timer0_flag_set_o(f0_o), .timer1_flag_set_o(f1_o)
	);
	// ********************************
	// tasks
	// ********************************
	task automatic tally_and_finish();
		$display("checks=%0d mismatches=%0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one classic cycle; request held until ack is seen at an edge
	task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] wd,
		output logic [7:0] rd);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= a;
		sel_i <= 4'h1;
		dat_i <= {24'h00_0000, wd};
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack_o !== 1'b1 && n < 20);
		rd = dat_o[7:0];
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		if (n >= 20)
		begin
			$display("ERROR t=%0t ack=%h exp=%h", $time, ack_o, 1'b1);
			err_count++;
			tally_and_finish();
		end
	endtask
	task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
		logic [7:0] v;
		wb(1'b0, a, 8'h00, v);
		chk(v, exp);
	endtask
	// bounded wait for the busy level; running out ends the run
	task automatic wait_busy(input logic lvl, input int lim);
		for (int n = 0; n < lim; n++)
		begin
			@(posedge clk_i);
			if (busy_o === lvl)
				return;
		end
		$display("ERROR t=%0t busy=%h exp=%h", $time, busy_o, lvl);
		err_count++;
		tally_and_finish();
	endtask
	// count busy cycles over a window where no start is expected
	task automatic quiet(input int cyc, output logic [7:0] cnt);
		cnt = 8'h00;
		repeat (cyc)
		begin
			@(posedge clk_i);
			if (busy_o !== 1'b0)
				cnt++;
		end
	endtask
	// preset results high so the clearing of unused bits shows
	task automatic conv(input logic [7:0] ctl);
		wb(1'b1, OFF_RESULT_HIGH, 8'hFF, r);
		wb(1'b1, OFF_RESULT_LOW, 8'hFF, r);
		wb(1'b1, OFF_CONTROL, ctl, r);
		wait_busy(1'b1, 10);
		wait_busy(1'b0, 30);
	endtask
	// ********************************
	// main sequence
	// ********************************
	initial
	begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		por_i <= 1'b0;
		rdchk(OFF_TRIG_SELECT, TRIG_SELECT_RESET);
		rdchk(OFF_CONTROL, CONTROL_RESET);
		wb(1'b1, OFF_TRIG_SELECT, 8'hFF, r);
		rdchk(OFF_TRIG_SELECT, 8'hF8);
		rdchk(4'h2, 8'h00);
		$display("register test done");
		res_i <= 10'h2B5;
		repeat (4) @(posedge clk_i);
		conv(8'h03);
		rdchk(OFF_RESULT_HIGH, 8'hAD);
		rdchk(OFF_RESULT_LOW, 8'h40);
		rdchk(OFF_CONTROL, 8'h01);
		conv(8'h83);
		rdchk(OFF_RESULT_HIGH, 8'h02);
		rdchk(OFF_RESULT_LOW, 8'hB5);
		$display("format test done");
		// each code starts on its own line's edge, once; no other line is raised
		for (int c = 1; c <= 20; c++)
		begin
			b0 = f0;
			b1 = f1;
			wb(1'b1, OFF_TRIG_SELECT, 8'(c << 3), r);
			wb(1'b1, OFF_CONTROL, 8'h01, r);
			u_src.set_line(c - 1, 1'b1);
			wait_busy(1'b1, 10);
			wait_busy(1'b0, 30);
			quiet(10, q);
			chk(q, 8'h00);
			u_src.set_line(c - 1, 1'b0);
			repeat (6) @(posedge clk_i);
			chk(8'(f0 - b0), 8'(c == 3));
			chk(8'(f1 - b1), 8'(c == 4));
		end
		// no code and reserved codes select nothing; timer flags still fire
		for (int i = 0; i < 3; i++)
		begin
			b0 = f0;
			b1 = f1;
			wb(1'b1, OFF_TRIG_SELECT, {nosel[i], 3'b000}, r);
			u_src.set_all(1'b1);
			quiet(12, q);
			chk(q, 8'h00);
			u_src.set_all(1'b0);
			repeat (6) @(posedge clk_i);
			chk(8'(f0 - b0), 8'h01);
			chk(8'(f1 - b1), 8'h01);
		end
		// an edge while disabled starts nothing
		wb(1'b1, OFF_TRIG_SELECT, 8'h08, r);
		wb(1'b1, OFF_CONTROL, 8'h00, r);
		u_src.set_line(0, 1'b1);
		quiet(12, q);
		chk(q, 8'h00);
		u_src.set_line(0, 1'b0);
		$display("trigger test done");
		// results survive a plain reset, the select does not
		wb(1'b1, OFF_RESULT_HIGH, 8'hA5, r);
		wb(1'b1, OFF_RESULT_LOW, 8'h3C, r);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		rdchk(OFF_RESULT_HIGH, 8'hA5);
		rdchk(OFF_RESULT_LOW, 8'h3C);
		rdchk(OFF_TRIG_SELECT, 8'h00);
		$display("reset test done");
		tally_and_finish();
	end
endmodule // adc_trigger_format_test
